// ### design/ssp_master.sv
// SPI master of the synchronous serial port: registers, clock divider, shift engine, interrupt.
// Assumes one 50 MHz clock; periodic_timer_i is a one-cycle pulse on that clock; sdi_i is a raw pin.
//
// Function
// - Completed byte moves to buffer, sets flag
// - Buffer write loads buffer and shifter together
// - Buffer write starts transfer immediately
// - Master drives clock, starts anytime
// - Receive-only still shifts and delivers bytes
// - Most significant bit shifted first
// - Rate: osc/4, /16, /64, timer/2
// - Clock idle level follows polarity bit
// - Edge select picks output change edge
// - First bit valid before first edge if edge select set
// - Sample select clear: sample mid-bit
// - Buffer-full reads one when byte held
// - Status upper two writable, rest read-only
// - Shift register has no software access
// - Control register fully readable and writable
`include "ssp_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module ssp_master
  import ssp_pkg::*;
#(
  parameter int HALF_W = 6
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire ssp_bus_req_t bus_req_i,
  output logic [7:0]        rdata_o,
  input  wire logic         periodic_timer_i,
  input  wire logic         sdi_i,
  output logic              sck_o,
  output logic              sdo_o,
  output logic              sdo_oe_b_o,
  output logic              irq_o
);

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (HALF_W < 6) begin : g_bad_width
      $error("HALF_W too narrow for the slowest divider");
    end
  endgenerate

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]        ctrl;
  logic              sample_point_select;
  logic              cke;
  logic              bf;
  logic [7:0]        data_buf;
  logic [7:0]        shreg;
  logic              irq_flag;
  logic              irq_mask;
  ssp_state_t        state;
  logic [2:0]        bit_cnt;
  logic              half;
  logic              mid_bit;
  logic [1:0]        mid_dly;
  logic [HALF_W-1:0] div_cnt;
  logic              sck;
  logic              serial_out_pin;
  logic              sdi_meta;
  logic              sdi_sync;

  // ****************************************
  // Decode
  // ****************************************
  // The shifter has no address of its own; only the buffer reaches it
  wire       hit_buf   = bus_req_i.addr == `SSP_ADDR_BUF;
  wire       hit_ctrl  = bus_req_i.addr == `SSP_ADDR_CTRL;
  wire       hit_stat  = bus_req_i.addr == `SSP_ADDR_STAT;
  wire       hit_istat = bus_req_i.addr == `SSP_ADDR_IRQ_STAT;
  wire       hit_imask = bus_req_i.addr == `SSP_ADDR_IRQ_MASK;
  wire       wr_buf    = bus_req_i.wr & hit_buf;
  wire       wr_ctrl   = bus_req_i.wr & hit_ctrl;
  wire       wr_stat   = bus_req_i.wr & hit_stat;
  wire       wr_istat  = bus_req_i.wr & hit_istat;
  wire       wr_imask  = bus_req_i.wr & hit_imask;
  wire       rd_buf    = bus_req_i.rd & hit_buf;

  wire       en        = ctrl[`SSP_CTRL_EN];
  wire       clock_polarity_select       = ctrl[`SSP_CTRL_CKP];
  wire       sdo_dis   = ctrl[`SSP_CTRL_SDO_DIS];
  wire [3:0] rate      = ctrl[`SSP_CTRL_RATE_HI:`SSP_CTRL_RATE_LO];
  wire       busy      = state == SSP_SHIFT;

  // Transfer begins on the buffer write itself
  wire       start     = wr_buf & en & ~busy;

  // ****************************************
  // Bit rate divider
  // ****************************************
  wire [HALF_W-1:0] half_len =
    (rate == SSP_RATE_DIV16) ? HALF_W'(`SSP_HALF_DIV16) :
    (rate == SSP_RATE_DIV64) ? HALF_W'(`SSP_HALF_DIV64) :
                               HALF_W'(`SSP_HALF_DIV4);
  wire       div_end   = div_cnt == half_len - HALF_W'(1);
  // Timer pulse toggles the clock, giving timer rate over two
  wire       div_tick  = (rate == SSP_RATE_TMR) ? periodic_timer_i : div_end;
  wire       tick      = busy & div_tick;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= '0;
    end else if (!busy || div_end) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + HALF_W'(1);
    end
  end

  // ****************************************
  // Input synchroniser
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      sdi_meta <= sdi_i;
      sdi_sync <= sdi_meta;
    end
  end

  // ****************************************
  // Shift engine
  // ****************************************
  wire       last      = bit_cnt == `SSP_LAST_BIT;
  wire       end_tick  = tick & half;
  wire       mid_tick  = tick & ~half;
  wire       done      = end_tick & last;
  // Sample at end of bit or at its middle
  wire       rx_bit    = (sample_point_select | mid_dly[1]) ? sdi_sync : mid_bit;
  wire [7:0] next_rx   = {shreg[6:0], rx_bit};
  // First half active when edge select clear, idle when set
  wire       sck_first = cke ? clock_polarity_select : ~clock_polarity_select;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= SSP_IDLE;
      shreg   <= `SSP_BYTE_RESET;
      bit_cnt <= '0;
      half    <= 1'b0;
      sck     <= 1'b0;
      serial_out_pin     <= 1'b0;
    end else if (!en) begin
      state   <= SSP_IDLE;
      bit_cnt <= '0;
      half    <= 1'b0;
      sck     <= clock_polarity_select;
    end else if (start) begin
      state   <= SSP_SHIFT;
      shreg   <= bus_req_i.wdata;
      serial_out_pin     <= bus_req_i.wdata[7];
      sck     <= sck_first;
      bit_cnt <= '0;
      half    <= 1'b0;
    end else if (mid_tick) begin
      half    <= 1'b1;
      sck     <= ~sck;
    end else if (end_tick) begin
      half    <= 1'b0;
      shreg   <= next_rx;
      serial_out_pin     <= shreg[6];
      bit_cnt <= bit_cnt + 3'h1;
      sck     <= last ? clock_polarity_select : sck_first;
      if (last) begin
        state <= SSP_IDLE;
      end
    end else if (!busy) begin
      sck     <= clock_polarity_select;
    end
  end

  // ****************************************
  // Mid-bit sample alignment
  // ****************************************
  // Mid tick delayed by the two synchroniser stages
  // Timer pulses need two clocks between them
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mid_dly <= 2'h0;
      mid_bit <= 1'b0;
    end else begin
      mid_dly <= {mid_dly[0], mid_tick};
      if (mid_dly[1]) begin
        mid_bit <= sdi_sync;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= `SSP_CTRL_RESET;
      sample_point_select  <= 1'(`SSP_STAT_RESET >> `SSP_STAT_SMP);
      cke  <= 1'(`SSP_STAT_RESET >> `SSP_STAT_CKE);
    end else begin
      if (wr_ctrl) begin
        ctrl <= bus_req_i.wdata;
      end
      if (wr_stat) begin
        sample_point_select <= bus_req_i.wdata[`SSP_STAT_SMP];
        cke <= bus_req_i.wdata[`SSP_STAT_CKE];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_buf <= `SSP_BYTE_RESET;
    end else if (start) begin
      data_buf <= bus_req_i.wdata;
    end else if (done) begin
      data_buf <= next_rx;
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bf <= 1'b0;
    end else if (done) begin
      bf <= 1'b1;
    end else if (rd_buf) begin
      bf <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_flag <= 1'b0;
      irq_mask <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      if (done) begin
        irq_flag <= 1'b1;
      end else if (wr_istat && bus_req_i.wdata[0]) begin
        irq_flag <= 1'b0;
      end
      if (wr_imask) begin
        irq_mask <= bus_req_i.wdata[0];
      end
      irq_o <= irq_flag & irq_mask;
    end
  end

  // ****************************************
  // Read path and pins
  // ****************************************
  wire [7:0] stat_val = {sample_point_select, cke, `SSP_ZERO_FILL, bf};
  wire [7:0] rd_mux =
    hit_buf   ? data_buf :
    hit_ctrl  ? ctrl :
    hit_stat  ? stat_val :
    hit_istat ? {7'h00, irq_flag} :
    hit_imask ? {7'h00, irq_mask} :
                8'h00;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o    <= 8'h00;
      sck_o      <= 1'b0;
      sdo_o      <= 1'b0;
      sdo_oe_b_o <= 1'b1;
    end else begin
      rdata_o    <= bus_req_i.rd ? rd_mux : 8'h00;
      sck_o      <= sck;
      sdo_o      <= serial_out_pin;
      sdo_oe_b_o <= ~(en & ~sdo_dis);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_buf_load_start: assert property (start |=> busy && data_buf == $past(bus_req_i.wdata)
                                     && shreg == $past(bus_req_i.wdata))
    else $error("buffer write did not load and start");

  a_first_bit_out: assert property (start |-> ##2 sdo_o == $past(bus_req_i.wdata[7], 2))
    else $error("first output bit is not the top bit");

  a_rx_byte_land: assert property (done |=> data_buf == $past(next_rx) && bf)
    else $error("received byte not delivered");

  a_irq_flag_set: assert property (done |=> irq_flag ##1 (irq_o || !$past(irq_mask)))
    else $error("interrupt flag not raised after byte");

  a_bf_read_clear: assert property (rd_buf && !done |=> !bf)
    else $error("buffer read left buffer-full set");

  a_fast_rate_len: assert property (start && rate == SSP_RATE_DIV4 ##1 en [*8] |-> ##24 done)
    else $error("fastest rate byte length wrong");

  a_sck_idle_lvl: assert property (!busy && $past(!busy) && $stable(clock_polarity_select) |=> sck_o == $past(clock_polarity_select))
    else $error("idle clock level differs from polarity");

  a_mid_data_hold: assert property (en && mid_tick |=> $stable(serial_out_pin))
    else $error("output changed at the middle of a bit");

  a_mid_sck_toggle: assert property (en && mid_tick |=> sck != $past(sck))
    else $error("no clock edge at the middle of a bit");

  a_stat_ro_bits: assert property (wr_stat && !done && !rd_buf |=> bf == $past(bf)
                                   && sample_point_select == $past(bus_req_i.wdata[7]))
    else $error("status write touched read-only bits");

  a_ctrl_rw: assert property (wr_ctrl ##1 bus_req_i.rd && hit_ctrl |=> rdata_o == $past(bus_req_i.wdata, 2))
    else $error("control register read back differs");

  a_done_sck_idle: assert property (done && en |=> sck == $past(clock_polarity_select))
    else $error("clock not idle after last bit");

  a_busy_wr_drop: assert property (wr_buf && busy && !done |=> data_buf == $past(data_buf))
    else $error("buffer changed by write during transfer");

  a_msb_next_out: assert property (end_tick && en && !last |=> serial_out_pin == $past(shreg[6]))
    else $error("next output bit is not the next lower bit");

  a_bit_advance: assert property (end_tick && en |=> bit_cnt == $past(bit_cnt) + 3'h1)
    else $error("bit counter did not advance");

  a_abort_idle: assert property (!en |=> !busy && sck == $past(clock_polarity_select))
    else $error("disabled port not idle");

  a_rx_only_runs: assert property (sdo_dis && start |=> busy)
    else $error("receive-only transfer did not run");

  a_oe_follow: assert property (1'b1 |=> sdo_oe_b_o == $past(!en || sdo_dis))
    else $error("data pin enable wrong");

  a_tmr_hold: assert property (busy && en && rate == SSP_RATE_TMR && !periodic_timer_i |=> $stable(sck))
    else $error("clock moved without a timer pulse");

  a_rx_end_take: assert property (end_tick && en && (sample_point_select || mid_dly[1]) |=> shreg[0] == $past(sdi_sync))
    else $error("end-of-bit sample not taken");

  a_rx_mid_take: assert property (end_tick && en && !sample_point_select && !mid_dly[1] |=> shreg[0] == $past(mid_bit))
    else $error("mid-bit sample not taken");

  a_bf_hold: assert property (!done && !rd_buf |=> bf == $past(bf))
    else $error("buffer-full changed without cause");

  a_irq_level: assert property (1'b1 |=> irq_o == $past(irq_flag && irq_mask))
    else $error("interrupt output not following flag and mask");

  c_byte_cke: cover property (done && cke);
  c_byte_tmr: cover property (done && rate == SSP_RATE_TMR);
  c_rx_only: cover property (done && sdo_dis && sample_point_select);
  c_irq_rise: cover property ($rose(irq_o));
  c_fast_mid: cover property (mid_dly[1] && end_tick);

endmodule // ssp_master

`default_nettype wire

// ### design/ssp_defines.svh
// Constants of the serial port master: register offsets, field positions, resets, divider counts.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSP_ADDR_BUF       8'h13
`define SSP_ADDR_CTRL      8'h14
`define SSP_ADDR_STAT      8'h94
`define SSP_ADDR_IRQ_STAT  8'h0C
`define SSP_ADDR_IRQ_MASK  8'h8C

// ****************************************
// Reset values
// ****************************************
`define SSP_CTRL_RESET     8'h00
`define SSP_STAT_RESET     8'h00
`define SSP_BYTE_RESET     8'h00

// ****************************************
// Field positions
// ****************************************
`define SSP_CTRL_SDO_DIS   6
`define SSP_CTRL_EN        5
`define SSP_CTRL_CKP       4
`define SSP_CTRL_RATE_HI   3
`define SSP_CTRL_RATE_LO   0
`define SSP_STAT_SMP       7
`define SSP_STAT_CKE       6
`define SSP_STAT_BF        0

// ****************************************
// Divider counts, half bit period in clocks; last bit index, status zero fill
// ****************************************
`define SSP_HALF_DIV4      2
`define SSP_HALF_DIV16     8
`define SSP_HALF_DIV64     32
`define SSP_LAST_BIT       3'h7
`define SSP_ZERO_FILL      5'h00

`endif

// ### design/ssp_pkg.sv
// Types of the serial port master: register request carrier, states, rate encodings.
// Assumes nothing from ssp_defines.svh; it includes no file.
package ssp_pkg;

  // ****************************************
  // Register request carrier
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssp_bus_req_t;

  // ****************************************
  // Engine state and bit rate selects
  // ****************************************
  typedef enum logic {
    SSP_IDLE  = 1'b0,
    SSP_SHIFT = 1'b1
  } ssp_state_t;

  typedef enum logic [3:0] {
    SSP_RATE_DIV4  = 4'h0,
    SSP_RATE_DIV16 = 4'h1,
    SSP_RATE_DIV64 = 4'h2,
    SSP_RATE_TMR   = 4'h3
  } ssp_rate_t;

endpackage

// ### testbench/ssp_slave_model.sv
// SPI slave partner of the serial port master bench.
// Assumes the bench supplies the mode bits and marks each frame with active_i.
`timescale 1ns/1ns
`default_nettype none

module ssp_slave_model (
  input  wire logic       clk_i,
  input  wire logic       active_i,
  input  wire logic       cpol_i,
  input  wire logic       cke_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       sck_i,
  input  wire logic       sdo_i,
  output logic            sdi_o,
  output logic [7:0]      rx_o
);
  int   lead  = 0;
  int   trail = 0;
  int   idx;
  logic idle_q = 1'b0;

  initial rx_o = 8'h00;

  // ****************************************
  // Edge counting and capture
  // ****************************************
  always @(sck_i) begin
    if (active_i && sck_i !== cpol_i) begin
      lead++;
      if (cke_i) rx_o = {rx_o[6:0], sdo_i};
    end else if (active_i) begin
      trail++;
      if (!cke_i) rx_o = {rx_o[6:0], sdo_i};
    end
  end

  // Released line toggles between frames
  always @(posedge clk_i) begin
    if (!active_i) begin
      lead   = 0;
      trail  = 0;
      idle_q <= ~idle_q;
    end
  end

  always_comb begin
    idx   = cke_i ? trail : (lead > 0 ? lead - 1 : 0);
    sdi_o = !active_i ? idle_q : (idx > 7 ? ~tx_i[0] : tx_i[7 - idx]);
  end
endmodule // ssp_slave_model

`default_nettype wire

// ### testbench/spi_master_serial_port_bench.sv
// Self-checking bench of the serial port master with an SPI slave model.
// Assumes the register map of ssp_defines.svh and the timing walk of the design.
`include "ssp_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module spi_master_serial_port_bench import ssp_pkg::*; ();
  logic         clk;
  logic         rst_b;
  ssp_bus_req_t req;
  logic [7:0]   rdata;
  logic         tmr = 1'b0;
  logic         serial_in_pin, sck, serial_out_pin, oe_b, irq;
  logic         act, cpol, cke;
  logic [7:0]   stx, srx, b;
  int           err_total  = 0;
  int           num_checks = 0;
  int           tcnt       = 0;
  logic [7:0]   ctv [5] = '{8'h20, 8'h31, 8'h22, 8'h70, 8'h33};
  logic [7:0]   stv [5] = '{8'h00, 8'hC0, 8'h40, 8'h80, 8'h40};
  logic         msk [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  int           hv  [5] = '{2, 8, 32, 2, 0};

  ssp_master DUT (.sys_clk_i(clk), .rst_b_i(rst_b), .bus_req_i(req), .rdata_o(rdata), .periodic_timer_i(tmr),
    .sdi_i(serial_in_pin), .sck_o(sck), .sdo_o(serial_out_pin), .sdo_oe_b_o(oe_b), .irq_o(irq));
  ssp_slave_model u_slave (.clk_i(clk), .active_i(act), .cpol_i(cpol), .cke_i(cke), .tx_i(stx),
    .sck_i(sck), .sdo_i(serial_out_pin), .sdi_o(serial_in_pin), .rx_o(srx));

  // ****************************************
  // Clock, timer pulse, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
    tmr  <= (tcnt == 4);
  end

  initial begin
    #400000;
    err_total++;
    results();
  end

  // ****************************************
  // Bus tasks and compare
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask

  task automatic nop(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    chk(n, e, rdata);
  endtask

  task automatic results;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_b = 1'b0;
    req   = '0;
    act   = 1'b0;
    cpol  = 1'b0;
    cke   = 1'b0;
    stx   = 8'h00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("reset pins", 8'h02, {5'h00, irq, oe_b, sck});
    rchk("status", `SSP_ADDR_STAT, 8'h00);
    rchk("control", `SSP_ADDR_CTRL, 8'h00);
    wr(`SSP_ADDR_CTRL, 8'h5A);
    rchk("control", `SSP_ADDR_CTRL, 8'h5A);
    wr(`SSP_ADDR_STAT, 8'hFF);
    rchk("status", `SSP_ADDR_STAT, 8'hC0);
    rchk("unmapped", 8'h55, 8'h00);
    wr(`SSP_ADDR_BUF, 8'h3C);
    nop(40);
    rchk("irq status", `SSP_ADDR_IRQ_STAT, 8'h00);
    chk("idle clock", 8'h01, {7'h00, sck});
    for (int i = 0; i < 5; i++) begin
      b = 8'hC3 ^ i[7:0];
      cpol <= ctv[i][4];
      cke  <= stv[i][6];
      stx  <= 8'h96 ^ i[7:0];
      wr(`SSP_ADDR_CTRL, ctv[i]);
      wr(`SSP_ADDR_STAT, stv[i]);
      wr(`SSP_ADDR_IRQ_MASK, {7'h00, msk[i]});
      nop(2);
      act <= 1'b1;
      chk("idle clock", {7'h00, ctv[i][4]}, {7'h00, sck});
      wr(`SSP_ADDR_BUF, b);
      wr(`SSP_ADDR_BUF, 8'h00);
      if (hv[i] > 0) begin
        nop(16 * hv[i]);
        chk("irq early", 8'h00, {7'h00, irq});
        @(posedge clk);
        chk("irq", {7'h00, msk[i]}, {7'h00, irq});
      end else begin
        nop(1);
        repeat (200) if (irq !== 1'b1) @(posedge clk);
        chk("irq timer", 8'h01, {7'h00, irq});
      end
      act <= 1'b0;
      chk("data enable", {7'h00, ctv[i][6]}, {7'h00, oe_b});
      if (!ctv[i][6]) chk("slave rx", b, srx);
      rchk("status full", `SSP_ADDR_STAT, stv[i] | 8'h01);
      rchk("irq status", `SSP_ADDR_IRQ_STAT, 8'h01);
      rchk("buffer", `SSP_ADDR_BUF, 8'h96 ^ i[7:0]);
      rchk("status empty", `SSP_ADDR_STAT, stv[i]);
      wr(`SSP_ADDR_IRQ_STAT, 8'h01);
      nop(2);
      chk("irq cleared", 8'h00, {7'h00, irq});
    end
    results();
  end
endmodule // spi_master_serial_port_bench

`default_nettype wire
